// ### gpwk_bank.sv
// thirteen-pin general purpose bank with wake events
// Behaviour
// - input pin read returns pin level, optionally inverted, at the read
// - writing the data bit of an input pin changes nothing
// - output pin drives written data bit, inverted when polarity is set
// - output pin read returns the last value written, not the pin
// - config bit 0 picks direction: 0 output, 1 input
// - config bit 1 picks polarity: 1 inverts, for input and output
// - config bit 7 picks open-drain or push-pull driver for outputs
// - polarity applies in all functions except wake status and summary bits of the either-edge pins
// - output pins never set a wake status bit, except the two either-edge pins
// - polarity picks the wake edge; non-inverted uses the rising edge
// - wake needs status bit, its enable bit and the global enable
// - wake status bits clear on writing one; zero leaves them
// - pins 1..8 map to first status/enable pair, 9..12 to the second
// - either-edge pins set wake status on both edges, ignoring polarity
// - in either-edge mode direction and driver settings do nothing
// - in either-edge mode polarity still shapes the data bit read
// - either-edge pin wakes only when enabled and either-edge mode selected
// - summary register holds one bit per either-edge pin, write one clears
// - either-edge status bits update on edges regardless of enable or mode
// - low data register holds pins 0..7, high holds pins 8..12
// - codec shared pin cannot wake; others wake only as inputs
`timescale 1ns/10ps
`default_nettype none
`include "gpwk_defs.svh"

module gpwk_bank (
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    input  wire gpwk_pkg::gpwk_byte_t addr_i,
    input  wire gpwk_pkg::gpwk_byte_t wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output var  gpwk_pkg::gpwk_byte_t rdata_o,
    input  wire gpwk_pkg::gpwk_pins_t pin_in_i,
    output var  gpwk_pkg::gpwk_pins_t pin_out_o,
    output var  gpwk_pkg::gpwk_pins_t pin_oe_o,
    output var  logic                wake_event_o
);
    import gpwk_pkg::*;

    logic       rst_meta_r;
    logic       rst_sync_r;
    logic       rstn;
    gpwk_byte_t cfg_r [`GPWK_NUM_PINS];
    gpwk_pins_t dout_r;
    gpwk_pins_t sync1_r;
    gpwk_pins_t sync2_r;
    gpwk_pins_t prev_r;
    gpwk_pins_t dir_in;
    gpwk_pins_t pol;
    gpwk_pins_t push_pull;
    gpwk_pins_t ee_sel;
    gpwk_pins_t input_like;
    gpwk_pins_t read_val;
    gpwk_pins_t any_edge;
    gpwk_pins_t act_edge;
    gpwk_pins_t set_wake;
    gpwk_pins_t wake_qual;
    gpwk_pins_t wsts_r;
    gpwk_pins_t wen_r;
    gpwk_pins_t wsts_clr;
    logic       gen_r;
    logic [1:0] ee_mode_r;
    logic [1:0] ee_sum_r;
    logic [1:0] ee_sum_clr;
    logic [1:0] ee_edge;
    gpwk_byte_t rdata_nxt;
    gpwk_pins_t pin_out_nxt;
    gpwk_pins_t pin_oe_nxt;
    logic       wake_nxt;
    logic       wr_lo;
    logic       wr_hi;

    // reset is released synchronously, asserted at once
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'h0;
            rst_sync_r <= 1'h0;
        end else begin
            rst_meta_r <= 1'h1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rstn = rst_sync_r;

    // pins come from outside; prev_r only reads the second stage
    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 13'h0000;
            sync2_r <= 13'h0000;
            prev_r  <= 13'h0000;
        end else begin
            sync1_r <= pin_in_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign wr_lo = wr_i && (addr_i == `GPWK_OFS_DATA_LO);
    assign wr_hi = wr_i && (addr_i == `GPWK_OFS_DATA_HI);

    assign ee_sel = {1'h0, ee_mode_r, 10'h000};
    assign any_edge = sync2_r ^ prev_r;
    assign ee_edge = {any_edge[`GPWK_PIN_EE1], any_edge[`GPWK_PIN_EE0]};

    genvar gi;
    generate
        for (gi = 0; gi < `GPWK_NUM_PINS; gi++) begin : g_pin
            localparam logic [7:0] CFG_OFS = `GPWK_OFS_CFG_BASE + 8'(gi);
            localparam int         BYTE_BIT = gi % 8;

            assign dir_in[gi]    = cfg_r[gi][`GPWK_CFG_DIR_BIT];
            assign pol[gi]       = cfg_r[gi][`GPWK_CFG_POL_BIT];
            assign push_pull[gi] = cfg_r[gi][`GPWK_CFG_DRV_BIT];
            // either-edge mode overrides direction
            assign input_like[gi] = dir_in[gi] | ee_sel[gi];
            // data read: sensed level through polarity, else stored bit
            assign read_val[gi] = input_like[gi] ?
                                  (sync2_r[gi] ^ pol[gi]) :
                                  dout_r[gi];
            // polarity picks the active edge of the raw pin
            assign act_edge[gi] = pol[gi] ? (prev_r[gi] & ~sync2_r[gi]) :
                                  (sync2_r[gi] & ~prev_r[gi]);

            always_ff @(posedge clock_i or negedge rstn) begin
                if (!rstn) begin
                    cfg_r[gi] <= `GPWK_CFG_RST;
                end else if (wr_i && addr_i == CFG_OFS) begin
                    cfg_r[gi] <= wdata_i;
                end
            end

            always_ff @(posedge clock_i or negedge rstn) begin
                if (!rstn) begin
                    dout_r[gi] <= 1'h0;
                end else if (((gi < 8) ? wr_lo : wr_hi) &&
                             !input_like[gi]) begin
                    dout_r[gi] <= wdata_i[BYTE_BIT];
                end
            end

            // drive value; open drain only pulls low
            always_comb begin
                if (input_like[gi]) begin
                    pin_out_nxt[gi] = 1'h0;
                    pin_oe_nxt[gi]  = 1'h0;
                end else if (push_pull[gi]) begin
                    pin_out_nxt[gi] = dout_r[gi] ^ pol[gi];
                    pin_oe_nxt[gi]  = 1'h1;
                end else begin
                    pin_out_nxt[gi] = 1'h0;
                    pin_oe_nxt[gi]  = ~(dout_r[gi] ^ pol[gi]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            pin_out_o <= 13'h0000;
            pin_oe_o  <= 13'h0000;
        end else begin
            pin_out_o <= pin_out_nxt;
            pin_oe_o  <= pin_oe_nxt;
        end
    end

    // either-edge pins set on any edge whatever the mode
    assign set_wake = (act_edge & dir_in & ~`GPWK_EE_PIN_MASK &
                       `GPWK_WAKE_CAP_MASK)
                    | (any_edge & `GPWK_EE_PIN_MASK);
    // either-edge pins qualify by mode, the rest except pin 0 by being inputs
    assign wake_qual = (`GPWK_EE_PIN_MASK & ee_sel)
                     | (~`GPWK_EE_PIN_MASK & dir_in &
                        `GPWK_WAKE_CAP_MASK);

    always_comb begin
        wsts_clr = 13'h0000;
        if (wr_i && addr_i == `GPWK_OFS_WSTS_FIRST) begin
            wsts_clr[8:1] = wdata_i;
        end
        if (wr_i && addr_i == `GPWK_OFS_WSTS_SECOND) begin
            wsts_clr[12:9] = wdata_i[3:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            wsts_r <= 13'h0000;
        end else begin
            wsts_r <= ((wsts_r & ~wsts_clr) | set_wake) &
                      `GPWK_WAKE_CAP_MASK;
        end
    end

    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            wen_r <= 13'h0000;
        end else if (wr_i && addr_i == `GPWK_OFS_WEN_FIRST) begin
            wen_r[8:1] <= wdata_i;
        end else if (wr_i && addr_i == `GPWK_OFS_WEN_SECOND) begin
            wen_r[12:9] <= wdata_i[3:0];
        end
    end

    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            gen_r     <= 1'h0;
            ee_mode_r <= 2'h0;
        end else if (wr_i && addr_i == `GPWK_OFS_WAKE_CTRL) begin
            gen_r     <= wdata_i[`GPWK_CTRL_GEN_BIT];
            ee_mode_r <= {wdata_i[`GPWK_CTRL_EE1_BIT],
                          wdata_i[`GPWK_CTRL_EE0_BIT]};
        end
    end

    assign ee_sum_clr = (wr_i && addr_i == `GPWK_OFS_EE_SUMMARY) ?
                        wdata_i[1:0] : 2'h0;

    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            ee_sum_r <= 2'h0;
        end else begin
            ee_sum_r <= (ee_sum_r & ~ee_sum_clr) | ee_edge;
        end
    end

    assign wake_nxt = gen_r && |(wsts_r & wen_r & wake_qual);

    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            wake_event_o <= 1'h0;
        end else begin
            wake_event_o <= wake_nxt;
        end
    end

    // unmapped addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (addr_i)
            `GPWK_OFS_DATA_LO:     rdata_nxt = read_val[7:0];
            `GPWK_OFS_DATA_HI:     rdata_nxt = {3'h0, read_val[12:8]};
            `GPWK_OFS_WSTS_FIRST:  rdata_nxt = wsts_r[8:1];
            `GPWK_OFS_WSTS_SECOND: rdata_nxt = {4'h0, wsts_r[12:9]};
            `GPWK_OFS_WEN_FIRST:   rdata_nxt = wen_r[8:1];
            `GPWK_OFS_WEN_SECOND:  rdata_nxt = {4'h0, wen_r[12:9]};
            `GPWK_OFS_WAKE_CTRL:   rdata_nxt = {5'h00, ee_mode_r, gen_r};
            `GPWK_OFS_EE_SUMMARY:  rdata_nxt = {6'h00, ee_sum_r};
            default: begin
                for (int k = 0; k < `GPWK_NUM_PINS; k++) begin
                    if (addr_i == `GPWK_OFS_CFG_BASE + 8'(k)) begin
                        rdata_nxt = cfg_r[k];
                    end
                end
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge rstn) begin
        if (!rstn) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rdata_nxt : 8'h00;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn);

    // pin 2 is the first of three pins the bench turns into an output
    sequence s_pin2_out_pp;
        !cfg_r[2][`GPWK_CFG_DIR_BIT] && cfg_r[2][`GPWK_CFG_DRV_BIT];
    endsequence

    sequence s_pin2_out_od;
        !cfg_r[2][`GPWK_CFG_DIR_BIT] && !cfg_r[2][`GPWK_CFG_DRV_BIT];
    endsequence

    sequence s_pin3_fall_inverted;
        cfg_r[3][`GPWK_CFG_DIR_BIT] && cfg_r[3][`GPWK_CFG_POL_BIT]
        ##0 (prev_r[3] && !sync2_r[3]);
    endsequence

    sequence s_pin1_rise_input;
        cfg_r[1][`GPWK_CFG_DIR_BIT] && !cfg_r[1][`GPWK_CFG_POL_BIT]
        ##0 (sync2_r[1] && !prev_r[1]);
    endsequence

    AST_RD_INPUT: assert property (
        rd_i && addr_i == `GPWK_OFS_DATA_LO && cfg_r[1][0]
        |=> rdata_o[1] == $past(sync2_r[1] ^ cfg_r[1][1]))
        else $error("input read does not return sensed level");

    AST_WR_INPUT: assert property (
        wr_lo && cfg_r[1][0] |=> $stable(dout_r[1]))
        else $error("write to input pin changed its data bit");

    AST_DRIVE_OUT: assert property (
        s_pin2_out_pp ##1 s_pin2_out_pp
        |-> pin_oe_o[2] && pin_out_o[2] == $past(dout_r[2] ^ cfg_r[2][1]))
        else $error("push-pull output does not follow data and polarity");

    AST_OD_DRIVE: assert property (
        s_pin2_out_od ##1 s_pin2_out_od
        |-> !pin_out_o[2] && pin_oe_o[2] == !$past(dout_r[2] ^ cfg_r[2][1]))
        else $error("open-drain output drives high or ignores its data");

    AST_RD_OUTPUT: assert property (
        rd_i && addr_i == `GPWK_OFS_DATA_LO && !cfg_r[2][0]
        |=> rdata_o[2] == $past(dout_r[2]))
        else $error("output read does not return last written value");

    AST_OUT_NOWAKE: assert property (
        !cfg_r[2][0] && !wsts_r[2] |=> !wsts_r[2])
        else $error("output pin set its wake status bit");

    AST_RISE_WAKE: assert property (
        s_pin1_rise_input |=> wsts_r[1])
        else $error("rising edge on input did not set wake status");

    AST_WAKE_GATE: assert property (
        !gen_r [*2] |-> !wake_event_o)
        else $error("wake event without global enable");

    AST_W1C: assert property (
        wr_i && addr_i == `GPWK_OFS_WSTS_FIRST && wdata_i[0] && !set_wake[1]
        |=> !wsts_r[1])
        else $error("write one did not clear wake status");

    AST_EE_BOTH: assert property (
        any_edge[`GPWK_PIN_EE0]
        |=> wsts_r[`GPWK_PIN_EE0] && ee_sum_r[0])
        else $error("either-edge pin edge did not set its status bits");

    AST_EE_HIZ: assert property (
        ee_mode_r[0] [*2] |-> !pin_oe_o[`GPWK_PIN_EE0])
        else $error("either-edge pin still driven");

    AST_EE1_HIZ: assert property (
        ee_mode_r[1] [*2] |-> !pin_oe_o[`GPWK_PIN_EE1])
        else $error("second either-edge pin still driven");

    AST_FALL_WAKE: assert property (
        s_pin3_fall_inverted |=> wsts_r[3])
        else $error("falling edge on inverted input did not set status");

    AST_W0_KEEPS: assert property (
        wr_i && addr_i == `GPWK_OFS_WSTS_FIRST && !wdata_i[0] && wsts_r[1]
        |=> wsts_r[1])
        else $error("write of zero cleared wake status");

    AST_WAKE_GLOBAL: assert property (
        wake_event_o |-> $past(gen_r))
        else $error("wake event raised while global enable was off");

    // only the either-edge pin pending and enabled, its mode off
    AST_EE_NEEDS_MODE: assert property (
        !ee_mode_r[0] && (wsts_r & wen_r) == (13'h0001 << `GPWK_PIN_EE0)
        |=> !wake_event_o)
        else $error("either-edge pin woke without its mode selected");

    AST_EE_POL_RD: assert property (
        rd_i && addr_i == `GPWK_OFS_DATA_HI && ee_mode_r[0]
        |=> rdata_o[2] == $past(sync2_r[10] ^ cfg_r[10][1]))
        else $error("either-edge data read ignores polarity");

    AST_EE_SUM_W1C: assert property (
        wr_i && addr_i == `GPWK_OFS_EE_SUMMARY && wdata_i[0] && !ee_edge[0]
        |=> !ee_sum_r[0])
        else $error("write one did not clear summary status");

    AST_WEN_MAP: assert property (
        wr_i && addr_i == `GPWK_OFS_WEN_SECOND
        |=> wen_r[12:9] == $past(wdata_i[3:0]))
        else $error("second group enables not taken from write data");

endmodule : gpwk_bank
`default_nettype wire

// ### gpwk_defs.svh
// register offsets, field positions and reset values of the pin bank
`ifndef GPWK_DEFS_SVH
`define GPWK_DEFS_SVH

`define GPWK_NUM_PINS        13
`define GPWK_OFS_DATA_LO     8'h15
`define GPWK_OFS_DATA_HI     8'h16
`define GPWK_OFS_CFG_BASE    8'h20
`define GPWK_OFS_WSTS_FIRST  8'h30
`define GPWK_OFS_WSTS_SECOND 8'h31
`define GPWK_OFS_WEN_FIRST   8'h32
`define GPWK_OFS_WEN_SECOND  8'h33
`define GPWK_OFS_WAKE_CTRL   8'h34
`define GPWK_OFS_EE_SUMMARY  8'h35

`define GPWK_CFG_DIR_BIT     0
`define GPWK_CFG_POL_BIT     1
`define GPWK_CFG_DRV_BIT     7
`define GPWK_CFG_RST         8'h01

`define GPWK_CTRL_GEN_BIT    0
`define GPWK_CTRL_EE0_BIT    1
`define GPWK_CTRL_EE1_BIT    2

`define GPWK_PIN_EE0         10
`define GPWK_PIN_EE1         11
`define GPWK_WAKE_CAP_MASK   13'h1FFE
`define GPWK_EE_PIN_MASK     13'h0C00

`endif

// ### gpwk_pkg.sv
// types shared by the pin bank
package gpwk_pkg;
    typedef logic [7:0]  gpwk_byte_t;
    typedef logic [12:0] gpwk_pins_t;
endpackage : gpwk_pkg

// ### gpwk_tb.sv
// self-checking bench for the thirteen-pin bank with wake events
`timescale 1ns/10ps
`default_nettype none
module tb;
    import gpwk_pkg::*;
    logic       clock_i  = 1'b0;
    logic       resetn_i = 1'b0;
    gpwk_byte_t addr_i   = 8'h00;
    gpwk_byte_t wdata_i  = 8'h00;
    logic       wr_i     = 1'b0;
    logic       rd_i     = 1'b0;
    gpwk_byte_t rdata_o;
    gpwk_pins_t pin_in_i = 13'h0000;
    gpwk_pins_t pin_out_o;
    gpwk_pins_t pin_oe_o;
    logic       wake_event_o;
    gpwk_byte_t rv;
    int         miscompares = 0;
    int         check_count = 0;
    int         cycles      = 0;

    always #4 clock_i = ~clock_i;

    gpwk_bank uut (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .addr_i       (addr_i),
        .wdata_i      (wdata_i),
        .wr_i         (wr_i),
        .rd_i         (rd_i),
        .rdata_o      (rdata_o),
        .pin_in_i     (pin_in_i),
        .pin_out_o    (pin_out_o),
        .pin_oe_o     (pin_oe_o),
        .wake_event_o (wake_event_o)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : settle

    task automatic wr(input gpwk_byte_t a, input gpwk_byte_t d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rc(input string n, input gpwk_byte_t a,
                      input gpwk_byte_t e);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        rv = rdata_o;
        chk(n, rv, e);
    endtask : rc

    // edge lands in status three edges later, wake one more
    task automatic setpin(input int i, input logic v);
        @(posedge clock_i);
        pin_in_i[i] <= v;
        settle(5);
    endtask : setpin

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        settle(3);
        rc("cfg0", 8'h20, 8'h01);
        rc("cfg12", 8'h2C, 8'h01);
        rc("unmapped", 8'h40, 8'h00);
        chk("oe_rst", pin_oe_o, 13'h0000);
        // pin 0 rises too but must not reach any status
        @(posedge clock_i);
        pin_in_i <= 13'h1A5B;
        settle(5);
        rc("data_lo", 8'h15, 8'h5B);
        rc("data_hi", 8'h16, 8'h1A);
        rc("wsts1", 8'h30, 8'h2D);
        rc("wsts2", 8'h31, 8'h0D);
        rc("summ", 8'h35, 8'h02);
        chk("wake_off", wake_event_o, 1'b0);
        wr(8'h30, 8'h00);
        rc("w0_keeps", 8'h30, 8'h2D);
        wr(8'h30, 8'h2D);
        wr(8'h31, 8'h0D);
        wr(8'h35, 8'h02);
        rc("w1_clr1", 8'h30, 8'h00);
        rc("w1_clr2", 8'h31, 8'h00);
        rc("summ_clr", 8'h35, 8'h00);
        wr(8'h15, 8'hFF);
        wr(8'h16, 8'hFF);
        settle(1);
        chk("in_wr_oe", pin_oe_o, 13'h0000);
        rc("in_wr_rd", 8'h15, 8'h5B);
        wr(8'h23, 8'h03);
        rc("inv_in", 8'h15, 8'h53);
        setpin(3, 1'b0);
        rc("inv_edge", 8'h30, 8'h04);
        // earlier ignored write must not have stored a one
        wr(8'h22, 8'h80);
        settle(1);
        chk("pp_out0", pin_out_o[2], 1'b0);
        chk("pp_oe", pin_oe_o[2], 1'b1);
        wr(8'h15, 8'h04);
        settle(1);
        chk("pp_out1", pin_out_o[2], 1'b1);
        rc("out_rd", 8'h15, 8'h5F);
        wr(8'h22, 8'h82);
        settle(1);
        chk("pp_inv", pin_out_o[2], 1'b0);
        wr(8'h22, 8'h00);
        settle(1);
        chk("od_oe1", pin_oe_o[2], 1'b0);
        chk("od_out1", pin_out_o[2], 1'b0);
        wr(8'h15, 8'h00);
        settle(1);
        chk("od_oe0", pin_oe_o[2], 1'b1);
        setpin(2, 1'b1);
        rc("out_nowake", 8'h30, 8'h04);
        wr(8'h30, 8'h04);
        setpin(1, 1'b0);
        setpin(1, 1'b1);
        rc("rise_sts", 8'h30, 8'h01);
        wr(8'h32, 8'h01);
        settle(2);
        chk("no_global", wake_event_o, 1'b0);
        wr(8'h34, 8'h01);
        settle(2);
        chk("wake_on", wake_event_o, 1'b1);
        wr(8'h30, 8'h01);
        settle(2);
        chk("wake_clr", wake_event_o, 1'b0);
        // pin 10 as plain output, either-edge mode still off
        wr(8'h2A, 8'h80);
        setpin(10, 1'b1);
        rc("ee_sts", 8'h31, 8'h02);
        rc("ee_summ", 8'h35, 8'h01);
        wr(8'h33, 8'h02);
        settle(2);
        chk("ee_nomode", wake_event_o, 1'b0);
        wr(8'h34, 8'h03);
        settle(2);
        chk("ee_wake", wake_event_o, 1'b1);
        chk("ee_oe", pin_oe_o[10], 1'b0);
        wr(8'h31, 8'h02);
        wr(8'h35, 8'h01);
        settle(2);
        chk("ee_clr", wake_event_o, 1'b0);
        setpin(10, 1'b0);
        chk("ee_fall", wake_event_o, 1'b1);
        rc("ee_summ2", 8'h35, 8'h01);
        wr(8'h2A, 8'h02);
        rc("ee_pol_rd", 8'h16, 8'h1E);
        // second either-edge pin: driven first, then released by its mode
        wr(8'h2B, 8'h80);
        settle(1);
        chk("ee1_drv", pin_oe_o[11], 1'b1);
        rc("cfg11", 8'h2B, 8'h80);
        wr(8'h34, 8'h07);
        settle(1);
        chk("ee1_oe", pin_oe_o[11], 1'b0);
        rc("ctrl", 8'h34, 8'h07);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
